// ### inc/fspc_pkg.sv
// fspc_pkg: constants, register map and types of the flash self-program control block.
// assumes a 250 MHz system clock and 32-bit classic wishbone register access.
package fspc_pkg;

  // register byte offsets
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_LOCK       = 8'h04;

  // control/status bit positions
  localparam int          CTRL_IE_BIT    = 7;
  localparam int          CTRL_BUSY_BIT  = 6;
  localparam int          CTRL_SIG_BIT   = 5;
  localparam int          CTRL_REEN_BIT  = 4;
  localparam int          CTRL_LSET_BIT  = 3;
  localparam int          CTRL_PGW_BIT   = 2;
  localparam int          CTRL_PGE_BIT   = 1;
  localparam int          CTRL_STORE_ENABLE_BIT = 0;

  // accepted patterns of the low five control bits
  localparam logic [4:0]  CMD_STORE      = 5'h01;
  localparam logic [4:0]  CMD_REEN       = 5'h11;
  localparam logic [4:0]  CMD_LOCK       = 5'h09;
  localparam logic [4:0]  CMD_PGWR       = 5'h05;
  localparam logic [4:0]  CMD_PGER       = 5'h03;

  // reset values
  localparam logic [7:0]  LOCK_RESET     = 8'hff;
  localparam logic [15:0] BUF_EMPTY      = 16'hffff;

  // lock byte field positions
  localparam int          LB_LO_BIT      = 0;
  localparam int          LB_HI_BIT      = 1;
  localparam int          APP_LO_BIT     = 2;
  localparam int          APP_HI_BIT     = 3;
  localparam int          BOOT_LO_BIT    = 4;
  localparam int          BOOT_HI_BIT    = 5;

  // section layout: word addresses at and above this are the no-read-while-write section
  localparam logic [15:0] NO_READ_WHILE_WRITE_SECTION_START     = 16'hf000;

  // timing
  localparam logic [2:0]  ARM_CYCLES     = 3'd4;
  localparam logic [2:0]  LOAD_CYCLES    = 3'd3;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          PROG_TIME_NS   = 4500000;
  localparam int          PROG_CYCLES    = PROG_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_LOCK  = 4'b1000
  } fspc_state_e;

endpackage

// ### rtl/fspc_prog_timer.sv
// fspc_prog_timer: times one flash programming operation.
// assumes start_i is a one-cycle pulse given only while not busy.
`timescale 1ns/1ps
module fspc_prog_timer #(
  parameter int CYCLES = fspc_pkg::PROG_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      done_o
);
  import fspc_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_q == CW'(1));
      if (start_i) begin
        cnt_q <= CW'(CYCLES);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end

endmodule // fspc_prog_timer

// ### rtl/fspc_lock_decode.sv
// fspc_lock_decode: decodes the lock byte into protection levels.
// assumes from_boot_i and vect_boot_i are levels from the core.
`timescale 1ns/1ps
module fspc_lock_decode (
  input  wire logic [7:0] lock_i,
  input  wire logic       from_boot_i,
  input  wire logic       vect_boot_i,
  output logic            app_wr_blk_o,
  output logic            app_rd_blk_o,
  output logic            boot_wr_blk_o,
  output logic            boot_rd_blk_o,
  output logic            ext_prog_blk_o,
  output logic            ext_verify_blk_o,
  output logic            fuse_lock_o,
  output logic            blb_lock_o,
  output logic            int_dis_o
);
  import fspc_pkg::*;

  always_comb begin
    // programmed bit reads 0; lower bit low means write blocked (modes 2,3)
    app_wr_blk_o     = !lock_i[APP_LO_BIT];
    boot_wr_blk_o    = !lock_i[BOOT_LO_BIT];
    // upper bit low means cross reads blocked (modes 3,4)
    app_rd_blk_o     = from_boot_i && !lock_i[APP_HI_BIT];
    boot_rd_blk_o    = !from_boot_i && !lock_i[BOOT_HI_BIT];
    ext_prog_blk_o   = !lock_i[LB_LO_BIT];
    fuse_lock_o      = !lock_i[LB_LO_BIT];
    ext_verify_blk_o = !lock_i[LB_LO_BIT] && !lock_i[LB_HI_BIT];
    blb_lock_o       = !lock_i[LB_LO_BIT] && !lock_i[LB_HI_BIT];
    int_dis_o        = (!from_boot_i && vect_boot_i && !lock_i[APP_HI_BIT])
                    || (from_boot_i && !vect_boot_i && !lock_i[BOOT_HI_BIT]);
  end

endmodule // fspc_lock_decode

// ### rtl/fspc_ctrl.sv
// fspc_ctrl: self-programming control/status register, arming window,
// temporary page buffer, lock bits and protection outputs.
// assumes the core pulses store_i/load_i one cycle per instruction with
// pointer and data registers valid in that cycle; flash macro reads the
// buffer through flash_idx_i and starts on the erase/write pulses.
`timescale 1ns/1ps
// How it works
// - ready irq while enabled, global on, idle
// - rww-section erase/write sets busy, blocks section
// - busy clears on re-enable or buffer load
// - signature read by load within three cycles
// - re-enable command unblocks; refused while an operation runs
// - re-enable write during loading discards buffer
// - lock-set store programs application and boot locks from r0 bits 5:2
// - lock-set bit clears on done or timeout
// - load returns lock or fuse by pointer bit0
// - page write stores buffer to pointer page
// - page erase clears pointer-selected page
// - write/erase bits clear on done, timeout or blocked store
// - stall core during no-rww section operation
// - plain store fills buffer word from r1:r0
// - store enable clears after use, held during op
// - unaccepted low-five patterns are ignored
// - six lock bits, reset by chip erase or rst_i
// - general lock mode 2 blocks external programming
// - general lock mode 3 blocks program and verify
// - application lock pair modes gate store/load
// - boot lock pair mirrors application pair
// - page from pointer 16:8, word from 7:1
// - words f000 and up form no-rww section
module fspc_ctrl #(
  parameter int         PROG_CYCLES = fspc_pkg::PROG_CYCLES,
  parameter int         BUF_WORDS   = 128,
  parameter logic [7:0] SIG_BYTE0   = 8'h5a,  // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1   = 8'h01,  // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2   = 8'h02   // arbitrary identity value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // core side
  input  wire logic        store_i,
  input  wire logic        load_i,
  input  wire logic [16:0] ptr_i,
  input  wire logic [7:0]  general_register_0_i,
  input  wire logic [7:0]  general_register_1_i,
  input  wire logic        from_boot_i,
  input  wire logic        vect_boot_i,
  input  wire logic        global_int_i,
  input  wire logic [7:0]  fuse_low_i,
  input  wire logic [7:0]  fuse_high_i,
  input  wire logic        chip_erase_i,
  output logic      [7:0]  load_data_o,
  output logic             load_valid_o,
  output logic             cpu_stall_o,
  output logic             rww_block_o,
  output logic             ready_irq_o,
  // flash macro side
  input  wire logic [6:0]  flash_idx_i,
  output logic      [15:0] flash_data_o,
  output logic      [8:0]  flash_page_o,
  output logic             flash_erase_o,
  output logic             flash_write_o,
  // protection levels
  output logic             app_write_block_o,
  output logic             app_read_block_o,
  output logic             boot_write_block_o,
  output logic             boot_read_block_o,
  output logic             ext_prog_block_o,
  output logic             ext_verify_block_o,
  output logic             fuse_locked_o,
  output logic             boot_lock_locked_o,
  output logic             int_disable_o
);
  import fspc_pkg::*;

  // control register bits
  logic        ready_interrupt_enable_q, section_busy_flag_q, signature_read_bit_q;
  logic        section_reenable_bit_q, lock_set_bit_q, page_write_bit_q;
  logic        page_erase_bit_q, store_enable_q;

  logic [2:0]  arm_cnt_q;
  fspc_state_e state_q;
  logic [7:0]  lock_q;
  logic [5:0]  lock_pend_q;
  logic        loading_q;
  logic        ack_q;
  logic [15:0] buf_q [BUF_WORDS];

  logic        wb_hit, wr_ctrl, cmd_ok, armed, st_go, ld_go, start_op, op_done;
  logic        expire, abort, clr_buf, no_read_while_write_section, wr_blk, store_only;
  logic [4:0]  cmd;
  logic [8:0]  page;
  logic [6:0]  word_idx;
  logic [7:0]  ctrl_byte;
  logic        app_wr_blk, app_rd_blk, boot_wr_blk, boot_rd_blk;
  logic        ext_prog_blk, ext_verify_blk, fuse_lock, blb_lock, int_dis;

  function automatic logic [7:0] sig_byte(input logic [1:0] idx);
    unique case (idx)
      2'd0:    sig_byte = SIG_BYTE0;
      2'd1:    sig_byte = SIG_BYTE1;
      2'd2:    sig_byte = SIG_BYTE2;
      default: sig_byte = 8'hff;
    endcase
  endfunction

  fspc_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (start_op),
    .done_o  (op_done)
  );

  fspc_lock_decode u_lock (
    .lock_i           (lock_q),
    .from_boot_i      (from_boot_i),
    .vect_boot_i      (vect_boot_i),
    .app_wr_blk_o     (app_wr_blk),
    .app_rd_blk_o     (app_rd_blk),
    .boot_wr_blk_o    (boot_wr_blk),
    .boot_rd_blk_o    (boot_rd_blk),
    .ext_prog_blk_o   (ext_prog_blk),
    .ext_verify_blk_o (ext_verify_blk),
    .fuse_lock_o      (fuse_lock),
    .blb_lock_o       (blb_lock),
    .int_dis_o        (int_dis)
  );

  always_comb begin
    wb_hit   = wb_cyc_i && wb_stb_i && !ack_q;
    wr_ctrl  = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0] && (wb_adr_i == REG_CTRL);
    cmd      = wb_dat_i[4:0];
    // signature read only pairs with plain store enable
    cmd_ok   = (state_q == ST_IDLE)
            && ((cmd == CMD_STORE) || (!wb_dat_i[CTRL_SIG_BIT]
            && ((cmd == CMD_REEN) || (cmd == CMD_LOCK)
            || (cmd == CMD_PGWR) || (cmd == CMD_PGER))));
    page     = ptr_i[16:8];
    word_idx = ptr_i[7:1];
    no_read_while_write_section     = {page, 7'd0} >= NO_READ_WHILE_WRITE_SECTION_START;
    wr_blk   = no_read_while_write_section ? boot_wr_blk : app_wr_blk;
    armed    = store_enable_q && (state_q == ST_IDLE) && (arm_cnt_q != 3'd0);
    st_go    = store_i && armed;
    ld_go    = load_i && armed && (signature_read_bit_q || lock_set_bit_q)
            && (arm_cnt_q > (ARM_CYCLES - LOAD_CYCLES));
    store_only = !(signature_read_bit_q || section_reenable_bit_q
            || lock_set_bit_q || page_write_bit_q || page_erase_bit_q);
    start_op = st_go && (lock_set_bit_q
            || ((page_write_bit_q || page_erase_bit_q) && !wr_blk));
    expire   = armed && (arm_cnt_q == 3'd1) && !st_go;
    abort    = wr_ctrl && wb_dat_i[CTRL_REEN_BIT] && loading_q;
    clr_buf  = abort || (op_done && (state_q == ST_WRITE));
    ctrl_byte = {ready_interrupt_enable_q, section_busy_flag_q, signature_read_bit_q,
                 section_reenable_bit_q, lock_set_bit_q, page_write_bit_q,
                 page_erase_bit_q, store_enable_q};
  end

  // wishbone slave: one wait state, writes land at the ack edge, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_q <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= {24'h0, ctrl_byte};
          REG_LOCK: wb_dat_o <= {24'h0, lock_q};
          default:  wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;

  // arming window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_cnt_q <= 3'd0;
    end else if (wr_ctrl && cmd_ok) begin
      arm_cnt_q <= ARM_CYCLES;
    end else if (st_go) begin
      arm_cnt_q <= 3'd0;
    end else if (arm_cnt_q != 3'd0) begin
      arm_cnt_q <= arm_cnt_q - 3'd1;
    end
  end

  // command bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {signature_read_bit_q, section_reenable_bit_q, lock_set_bit_q} <= 3'h0;
      {page_write_bit_q, page_erase_bit_q, store_enable_q}           <= 3'h0;
    end else if (wr_ctrl && cmd_ok) begin
      signature_read_bit_q   <= wb_dat_i[CTRL_SIG_BIT];
      section_reenable_bit_q <= wb_dat_i[CTRL_REEN_BIT];
      lock_set_bit_q         <= wb_dat_i[CTRL_LSET_BIT];
      page_write_bit_q       <= wb_dat_i[CTRL_PGW_BIT];
      page_erase_bit_q       <= wb_dat_i[CTRL_PGE_BIT];
      store_enable_q         <= wb_dat_i[CTRL_STORE_ENABLE_BIT];
    end else if (op_done || expire || (st_go && !start_op)) begin
      // held through an operation, dropped on done, timeout or simple store
      signature_read_bit_q   <= 1'b0;
      section_reenable_bit_q <= 1'b0;
      lock_set_bit_q         <= 1'b0;
      page_write_bit_q       <= 1'b0;
      page_erase_bit_q       <= 1'b0;
      store_enable_q         <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_interrupt_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      ready_interrupt_enable_q <= wb_dat_i[CTRL_IE_BIT];
    end
  end

  // section busy flag: set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      section_busy_flag_q <= 1'b0;
    end else if (start_op && !lock_set_bit_q && !no_read_while_write_section) begin
      section_busy_flag_q <= 1'b1;
    end else if (st_go && (section_reenable_bit_q || store_only)) begin
      section_busy_flag_q <= 1'b0;
    end
  end

  // operation sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_op && lock_set_bit_q) begin
            state_q <= ST_LOCK;
          end else if (start_op && page_erase_bit_q) begin
            state_q <= ST_ERASE;
          end else if (start_op) begin
            state_q <= ST_WRITE;
          end
        end
        ST_ERASE, ST_WRITE, ST_LOCK: begin
          if (op_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // flash macro requests; data registers are not used for erase/write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      flash_page_o  <= 9'h0;
      cpu_stall_o   <= 1'b0;
    end else begin
      flash_erase_o <= start_op && !lock_set_bit_q && page_erase_bit_q;
      flash_write_o <= start_op && !lock_set_bit_q && page_write_bit_q;
      if (start_op && !lock_set_bit_q) begin
        flash_page_o <= page;
      end
      if (start_op && !lock_set_bit_q && no_read_while_write_section) begin
        cpu_stall_o <= 1'b1;
      end else if (op_done) begin
        cpu_stall_o <= 1'b0;
      end
    end
  end

  // temporary page buffer and its loading flag
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_buf) begin
      loading_q <= 1'b0;
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_q[i] <= BUF_EMPTY;
      end
    end else if (st_go && store_only) begin
      loading_q       <= 1'b1;
      buf_q[word_idx] <= {general_register_1_i, general_register_0_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_data_o <= BUF_EMPTY;
    end else begin
      flash_data_o <= buf_q[flash_idx_i];
    end
  end

  // lock bits: programming only clears, chip erase restores
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q      <= LOCK_RESET;
      lock_pend_q <= 6'h3f;
    end else begin
      if (start_op && lock_set_bit_q) begin
        lock_pend_q <= {general_register_0_i[5:2], 2'b11};
      end
      if (chip_erase_i) begin
        lock_q <= LOCK_RESET;
      end else if (op_done && (state_q == ST_LOCK)) begin
        lock_q <= lock_q & {2'b11, lock_pend_q};
      end
    end
  end

  // special loads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_valid_o <= 1'b0;
      load_data_o  <= 8'h0;
    end else begin
      load_valid_o <= ld_go;
      if (ld_go && signature_read_bit_q) begin
        load_data_o <= sig_byte(ptr_i[2:1]);
      end else if (ld_go && ptr_i[0]) begin
        load_data_o <= lock_q;
      end else if (ld_go) begin
        load_data_o <= ptr_i[1] ? fuse_high_i : fuse_low_i;
      end
    end
  end

  // status and protection outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {ready_irq_o, rww_block_o, app_write_block_o, app_read_block_o} <= 4'h0;
      {boot_write_block_o, boot_read_block_o, ext_prog_block_o, ext_verify_block_o} <= 4'h0;
      {fuse_locked_o, boot_lock_locked_o, int_disable_o} <= 3'h0;
    end else begin
      ready_irq_o        <= ready_interrupt_enable_q && global_int_i
                         && !store_enable_q;
      rww_block_o        <= section_busy_flag_q;
      app_write_block_o  <= app_wr_blk;
      app_read_block_o   <= app_rd_blk;
      boot_write_block_o <= boot_wr_blk;
      boot_read_block_o  <= boot_rd_blk;
      ext_prog_block_o   <= ext_prog_blk;
      ext_verify_block_o <= ext_verify_blk;
      fuse_locked_o      <= fuse_lock;
      boot_lock_locked_o <= blb_lock;
      int_disable_o      <= int_dis;
    end
  end

endmodule // fspc_ctrl

// ### testbench/fspc_core_model.sv
// fspc_core_model: core issuing store/load program instructions.
// assumes the bench calls op() once per armed command.
`timescale 1ns/1ps
module fspc_core_model (
  input  wire logic        clk_i,
  output logic             store_o,
  output logic             load_o,
  output logic      [16:0] ptr_o,
  output logic      [7:0]  r0_o,
  output logic      [7:0]  r1_o
);
  initial begin
    {store_o, load_o, ptr_o, r0_o, r1_o} = '0;
  end
  // one instruction a call, operands valid only in its cycle
  task automatic op(input logic st, input logic [16:0] p, input logic [7:0] a, b);
    @(posedge clk_i);
    {store_o, load_o, ptr_o, r0_o, r1_o} <= {st, !st, p, a, b};
    @(posedge clk_i);
    {store_o, load_o, ptr_o, r0_o, r1_o} <= {2'b00, ~p, ~a, ~b};
  endtask
endmodule // fspc_core_model

// ### testbench/fspc_ctrl_checker.sv
// fspc_ctrl_checker: port assertions of the self-program control block.
// assumes a bind to fspc_ctrl; one clock, synchronous reset.
`timescale 1ns/1ps
module fspc_ctrl_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       store_i,
  input wire logic       load_i,
  input wire logic       global_int_i,
  input wire logic       load_valid_o,
  input wire logic       cpu_stall_o,
  input wire logic       rww_block_o,
  input wire logic       ready_irq_o,
  input wire logic       flash_erase_o,
  input wire logic       flash_write_o,
  input wire logic [8:0] flash_page_o,
  input wire logic       app_write_block_o,
  input wire logic       fuse_locked_o,
  input wire logic       ext_prog_block_o
);
  import fspc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_irq; !global_int_i |=> !ready_irq_o; endproperty
  a_irq: assert property (p_irq) else $error("irq without global");
  property p_rww; flash_erase_o && flash_page_o < NO_READ_WHILE_WRITE_SECTION_START[15:7] |=> rww_block_o; endproperty
  a_rww: assert property (p_rww) else $error("section not blocked");
  property p_stall; (flash_erase_o || flash_write_o) && flash_page_o >= NO_READ_WHILE_WRITE_SECTION_START[15:7]
    |=> cpu_stall_o [*4]; endproperty
  a_stall: assert property (p_stall) else $error("core not stalled");
  property p_load; load_valid_o |-> $past(load_i); endproperty
  a_load: assert property (p_load) else $error("load answer without load");
  property p_erase; flash_erase_o |-> $past(store_i) && !flash_write_o; endproperty
  a_erase: assert property (p_erase) else $error("erase without store");
  property p_write; flash_write_o |-> $past(store_i) ##1 !flash_write_o; endproperty
  a_write: assert property (p_write) else $error("write pulse wrong");
  property p_appwr; flash_erase_o |-> !(app_write_block_o && flash_page_o < 9'h1e0); endproperty
  a_appwr: assert property (p_appwr) else $error("erase of locked section");
  property p_fuse; fuse_locked_o |-> ext_prog_block_o; endproperty
  a_fuse: assert property (p_fuse) else $error("fuse lock without prog lock");
endmodule // fspc_ctrl_checker
bind fspc_ctrl fspc_ctrl_checker fspc_ctrl_checker_i (.clk_i, .rst_i, .store_i, .load_i,
  .global_int_i, .load_valid_o, .cpu_stall_o, .rww_block_o, .ready_irq_o, .flash_erase_o,
  .flash_write_o, .flash_page_o, .app_write_block_o, .fuse_locked_o, .ext_prog_block_o);

// ### testbench/fspc_ctrl_bench.sv
// fspc_ctrl_bench: self-checking bench of the self-program control block.
// assumes fspc_core_model on the core side and wishbone register access.
`timescale 1ns/1ps
module fspc_ctrl_bench;
  import fspc_pkg::*;
  localparam int         PC   = 20;
  localparam logic [7:0] SIG0 = 8'hc3;  // arbitrary value
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic        global_int_i = 0, chip_erase_i = 0, from_boot_i = 0, vect_boot_i = 0;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [6:0]  flash_idx_i = 7'h00, wi;
  logic [7:0]  wb_adr_i = 8'h00, fuse_low_i, fuse_high_i, d0, d1, load_data_o;
  logic [7:0]  general_register_0_i, general_register_1_i;
  logic [8:0]  flash_page_o;
  logic [15:0] flash_data_o;
  logic [16:0] ptr_i;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, store_i, load_i, load_valid_o, cpu_stall_o, rww_block_o, ready_irq_o;
  logic        flash_erase_o, flash_write_o, app_write_block_o, app_read_block_o, int_disable_o;
  logic        boot_write_block_o, boot_read_block_o, ext_prog_block_o, ext_verify_block_o;
  logic        fuse_locked_o, boot_lock_locked_o;
  wire  [8:0]  prot_w = {app_write_block_o, app_read_block_o, boot_write_block_o,
    boot_read_block_o, ext_prog_block_o, ext_verify_block_o, fuse_locked_o,
    boot_lock_locked_o, int_disable_o};
  logic [31:0] exp_q[$];
  int          n_mismatch = 0, check_count = 0, cyc_n = 0;
  fspc_ctrl #(.PROG_CYCLES(PC), .SIG_BYTE0(SIG0)) fspc_ctrl_i (.*);
  fspc_core_model fspc_core_model_i (.clk_i, .store_o(store_i), .load_o(load_i), .ptr_o(ptr_i),
    .r0_o(general_register_0_i), .r1_o(general_register_1_i));
  always #2 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    // wait for the answer; only the cycle ceiling ends a hang
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic ctl(input logic [7:0] v);
    wb(1'b1, REG_CTRL, {24'h0, v});
  endtask
  task automatic op(input logic st, input logic [16:0] p, input logic [7:0] a, b);
    fspc_core_model_i.op(st, p, a, b);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // results in arrival order against the oldest note
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 3000) begin
      n_mismatch++;
      print_verdict();
    end
    if ((wb_ack_o === 1'b1 && wb_we_i === 1'b0) || load_valid_o === 1'b1)
      chk(load_valid_o ? {24'h0, load_data_o} : wb_dat_o, exp_q.size() ? exp_q.pop_front() : 'x);
    if (flash_erase_o === 1'b1 || flash_write_o === 1'b1)
      chk({23'h0, flash_page_o}, exp_q.size() ? exp_q.pop_front() : 'x);
  end
  initial begin
    void'($urandom(82999));
    {fuse_low_i, fuse_high_i, d0, d1} <= $urandom;
    wi = 7'($urandom);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_CTRL, 32'h0);
    rd(REG_LOCK, 32'hff);
    global_int_i <= 1'b1;
    ctl(8'h80);
    repeat (2) @(negedge clk_i);
    chk({31'h0, ready_irq_o}, 32'h1);
    ctl(8'h03);
    exp_q.push_back(32'h5);
    op(1'b1, {9'h5, 8'h0}, d0, d1);
    ctl(8'h11);
    rd(REG_CTRL, 32'h43);
    repeat (PC + 4) @(posedge clk_i);
    rd(REG_CTRL, 32'h40);
    ctl(8'h11);
    op(1'b1, 17'h0, 8'h0, 8'h0);
    rd(REG_CTRL, 32'h0);
    ctl(8'h01);
    op(1'b1, {9'h0, wi, 1'b1}, d0, d1);
    flash_idx_i <= wi;
    repeat (2) @(negedge clk_i);
    chk({16'h0, flash_data_o}, {16'h0, d1, d0});
    ctl(8'h11);
    repeat (2) @(negedge clk_i);
    chk({16'h0, flash_data_o}, 32'hffff);
    ctl(8'h05);
    repeat (6) @(posedge clk_i);
    rd(REG_CTRL, 32'h0);
    ctl(8'h07);
    rd(REG_CTRL, 32'h0);
    ctl(8'h09);
    op(1'b1, 17'h0, 8'hfb, d1);
    repeat (PC + 4) @(posedge clk_i);
    rd(REG_LOCK, 32'hfb);
    rd(REG_CTRL, 32'h0);
    chk({31'h0, app_write_block_o}, 32'h1);
    ctl(8'h03);
    op(1'b1, {9'h5, 8'h0}, d0, d1);
    rd(REG_CTRL, 32'h0);
    ctl(8'h09);
    exp_q.push_back(32'hfb);
    op(1'b0, 17'h1, 8'h0, 8'h0);
    ctl(8'h09);
    exp_q.push_back({24'h0, fuse_low_i});
    op(1'b0, 17'h0, 8'h0, 8'h0);
    ctl(8'h21);
    exp_q.push_back({24'h0, SIG0});
    op(1'b0, 17'h0, 8'h0, 8'h0);
    ctl(8'h05);
    exp_q.push_back(32'h1f0);
    op(1'b1, {9'h1f0, 8'h0}, d0, d1);
    repeat (PC + 4) @(posedge clk_i);
    rd(REG_CTRL, 32'h0);
    ctl(8'h09);
    op(1'b1, 17'h0, 8'h00, d1);
    repeat (PC + 4) @(posedge clk_i);
    rd(REG_LOCK, 32'hc3);
    vect_boot_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk({23'h0, prot_w}, 32'h161);
    @(posedge clk_i);
    {from_boot_i, vect_boot_i} <= 2'b10;
    repeat (2) @(negedge clk_i);
    chk({23'h0, prot_w}, 32'h1c1);
    @(posedge clk_i);
    chip_erase_i <= 1'b1;
    @(posedge clk_i);
    chip_erase_i <= 1'b0;
    rd(REG_LOCK, 32'hff);
    print_verdict();
  end
endmodule // fspc_ctrl_bench
